// ===== mac_pkg.sv
// Shared constants and carriers for the MAC configuration and
// transmit-queue block.
// Assumes a 32-bit AXI4-Lite register bus and a 200 MHz clock.
package mac_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CFG     = 8'h04;
  localparam logic [7:0] OFS_SR      = 8'h08;
  localparam logic [7:0] OFS_TAR     = 8'h0C;
  localparam logic [7:0] OFS_TCR     = 8'h10;
  localparam logic [7:0] OFS_TSR     = 8'h14;
  localparam logic [7:0] OFS_HASH_LO = 8'h90;
  localparam logic [7:0] OFS_HASH_HI = 8'h94;
  // Control register fields
  localparam int CTRL_BUMP   = 6;
  localparam int CTRL_PERMIT = 7;
  localparam int CTRL_BP     = 8;
  // Configuration register fields
  localparam int CFG_RATE  = 0;
  localparam int CFG_FD    = 1;
  localparam int CFG_CAF   = 4;
  localparam int CFG_NBC   = 5;
  localparam int CFG_MTI   = 6;
  localparam int CFG_UNI   = 7;
  localparam int CFG_BIG   = 8;
  localparam int CFG_CLK   = 10;
  localparam int CFG_RTY   = 12;
  localparam int CFG_RMII  = 13;
  localparam logic [31:0] CFG_WMASK = 32'h0000_3DF3;
  localparam logic [31:0] CFG_RESET = 32'h0000_0800;
  // Status register fields
  localparam int SR_MDIO = 1;
  localparam int SR_BUSY = 2;
  // Transmit control and status fields
  localparam int LEN_W    = 11;
  localparam int TCR_SKIP_FCS_APPEND = 15;
  localparam int TSR_OVR  = 0;
  localparam int TSR_COL  = 1;
  localparam int TSR_RLE  = 2;
  localparam int TSR_IDLE = 3;
  localparam int TSR_BNQ  = 4;
  localparam int TSR_COMP = 5;
  localparam int TSR_UND  = 6;
  // Frame size limits in bytes
  localparam logic [LEN_W-1:0] RX_MAX_STD  = 11'd1518;
  localparam logic [LEN_W-1:0] RX_MAX_LONG = 11'd1522;
  localparam logic [LEN_W-1:0] TX_MAX_FCS  = 11'd1514;
  localparam logic [LEN_W-1:0] TX_MAX_RAW  = 11'd1518;
  // Timing counts
  localparam logic [6:0] JAM_BITS      = 7'd64;
  localparam logic [5:0] MDC_HALF_BASE = 6'd4;
  localparam logic [2:0] TX_MIN_WORDS  = 3'd2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Transmit queue occupancy, Gray coded
  typedef enum logic [1:0] {
    TQ_EMPTY = 2'b00,
    TQ_ONE   = 2'b01,
    TQ_TWO   = 2'b11
  } txq_state_e;
  // One queued transmit frame
  typedef struct packed {
    logic [31:0]      addr;
    logic [LEN_W-1:0] len;
    logic             nocrc;
  } tx_desc_s;
endpackage

// ===== mac_cfg_txq.sv
// MAC configuration, status and transmit address/length queue.
// Assumes an AXI4-Lite master on the register side, a transmit DMA and
// PHY front end on the other, all synchronous to aclk.
// What this block does
// - Bump bit pulses all statistics counters; permit bit makes them writable.
// - Back pressure in half duplex jams each received frame for 64 bits.
// - Rate bit only reports 100 or 10 Mbit/s, nothing else.
// - Full duplex makes transmit ignore collision and carrier sense.
// - Accept-every-frame bit passes every valid frame.
// - Broadcast reject bit drops all-ones destination frames unless accept-every-frame is set or the specific address matches.
// - Hash enables accept multicast or unicast frames hitting a hash bit.
// - Destination CRC gives a 6-bit index into a 64-bit hash.
// - Receive limit 1518 bytes, or 1522 with long-frame bit.
// - Management clock is master clock over 8/16/32/64; resets to 32.
// - Backoff test bit forces one slot time; keep clear normally.
// - Reduced-interface bit selects RMII when one, MII when zero.
// - Status shows management data pin in bit 1, busy in bit 2.
// - Address write sets frame start; read gives buffer in use.
// - Nonzero length write starts a frame; read gives full count.
// - Lengths above 1514, or 1518 without CRC, go out oversize.
// - Address, length, no-CRC are double buffered; address first.
// - Transmission waits for two words in the transmit FIFO.
// - No-CRC length includes CRC; reads give current frame setting.
// - Address or length write with no free slot flags overrun.
// - Collision and complete flags set by events; write one clears.
// - Idle flag high with nothing pending, cleared by length write.
// - Slot-free flag clears while one waits and one transmits.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module mac_cfg_txq (
  input  wire logic              aclk,            // Master clock
  input  wire logic              aresetn,         // Sync reset, low
  input  wire logic [7:0]        awaddr,          // Write address
  input  wire logic              awvalid,         // Write addr valid
  output logic                   awready,         // Write addr ready
  input  wire logic [31:0]       wdata,           // Write data
  input  wire logic [3:0]        wstrb,           // Byte enables
  input  wire logic              wvalid,          // Write data valid
  output logic                   wready,          // Write data ready
  output logic [1:0]             bresp,           // Write response
  output logic                   bvalid,          // Write resp valid
  input  wire logic              bready,          // Write resp ready
  input  wire logic [7:0]        araddr,          // Read address
  input  wire logic              arvalid,         // Read addr valid
  output logic                   arready,         // Read addr ready
  output logic [31:0]            rdata,           // Read data
  output logic [1:0]             rresp,           // Read response
  output logic                   rvalid,          // Read data valid
  input  wire logic              rready,          // Read data ready
  output logic                   stats_bump_all,  // Counter +1 pulse
  output logic                   stats_write_permit, // Counters writable
  input  wire logic              rx_frame_start,  // Receive frame begins
  input  wire logic              bit_tick,        // One line bit time
  output logic                   back_pressure_force, // Jam transmit
  output logic                   rate_indicator,  // 1 = 100 Mbit/s
  output logic                   full_duplex_select, // Ignore col/crs
  output logic                   backoff_test_mode, // One slot backoff
  output logic                   rmii_select,     // 1 = RMII, 0 = MII
  output logic [10:0]            rx_max_len,      // Receive limit, bytes
  input  wire logic [47:0]       dest_addr,       // Received destination
  input  wire logic              dest_valid,      // Destination ready
  input  wire logic              sa_match,        // Specific addr hit
  output logic                   frame_accept,    // Store this frame
  output logic                   mdc_out,         // Management clock
  input  wire logic              mdio_in,         // Management data pin
  input  wire logic              mgmt_busy,       // Management running
  output mac_pkg::tx_desc_s      tx_desc,         // Frame in transmit
  output logic                   tx_go,           // Frame may go out
  output logic                   tx_oversize,     // Over size limit
  input  wire logic [2:0]        tx_fifo_words,   // Words in tx FIFO
  input  wire logic              tx_done,         // Frame finished
  input  wire logic              tx_col,          // Collision seen
  input  wire logic              tx_retry_limit,  // Retries exhausted
  input  wire logic              tx_underrun      // DMA too late
);
  // Merge bytes of a write under its strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // Reflected CRC-32 over the 48 address bits, LSB first
  function automatic logic [31:0] dest_crc(input logic [47:0] a);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < 48; i++) begin
      c = (c[0] ^ a[i]) ? ((c >> 1) ^ 32'hEDB8_8320) : (c >> 1);
    end
    return c;
  endfunction

  logic              aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [7:0]        aw_addr_reg;
  logic [31:0]       w_data_reg, rdata_reg;
  logic [3:0]        w_strb_reg;
  logic [1:0]        bresp_reg, rresp_reg;
  logic [31:0]       cfg_reg, hash_lo_reg, hash_hi_reg, tar_reg;
  logic              bp_reg, permit_reg, bump_reg;
  logic [6:0]        tsr_flags_reg;
  logic [5:0]        mdc_cnt_reg;
  logic              mdc_reg, accept_reg;
  logic [6:0]        jam_cnt_reg;
  mac_pkg::txq_state_e q_reg, q_next;
  mac_pkg::tx_desc_s   cur_reg, pend_reg, cur_next, pend_next;
  logic              start_next;

  // Bus handshakes
  wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire do_read  = arvalid & ~rvalid_reg;
  assign awready = ~aw_held_reg & ~bvalid_reg;
  assign wready  = ~w_held_reg & ~bvalid_reg;
  assign arready = ~rvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  // Write address decode
  wire wr_ctrl = do_write & (aw_addr_reg == mac_pkg::OFS_CTRL);
  wire wr_cfg  = do_write & (aw_addr_reg == mac_pkg::OFS_CFG);
  wire wr_tar  = do_write & (aw_addr_reg == mac_pkg::OFS_TAR);
  wire wr_tcr  = do_write & (aw_addr_reg == mac_pkg::OFS_TCR);
  wire wr_tsr  = do_write & (aw_addr_reg == mac_pkg::OFS_TSR);
  wire wr_hlo  = do_write & (aw_addr_reg == mac_pkg::OFS_HASH_LO);
  wire wr_hhi  = do_write & (aw_addr_reg == mac_pkg::OFS_HASH_HI);
  wire wr_hit  = wr_ctrl | wr_cfg | wr_tar | wr_tcr | wr_tsr |
                 wr_hlo | wr_hhi | (aw_addr_reg == mac_pkg::OFS_SR);
  wire [31:0] wmerged = merge(32'h0000_0000, w_data_reg, w_strb_reg);

  // Length write that queues a frame
  wire [10:0] wr_len   = wmerged[10:0];
  wire        len_go   = wr_tcr & (|w_strb_reg[1:0]) & (wr_len != 11'h000);
  wire        slot_free = (q_reg != mac_pkg::TQ_TWO);
  wire        tx_idle   = (q_reg == mac_pkg::TQ_EMPTY);

  // Transmit status word
  wire [31:0] tsr_word = {25'h0, tsr_flags_reg[6:5], slot_free, tx_idle,
                          tsr_flags_reg[2:0]};
  // Address in use: frame in flight, else the staged one
  wire [31:0] tar_view = tx_idle ? tar_reg : cur_reg.addr;
  wire [31:0] tcr_view = {16'h0, cur_reg.nocrc, 4'h0, cur_reg.len};
  wire [31:0] sr_word  = {29'h0, mgmt_busy, mdio_in, 1'b0};
  wire [31:0] ctrl_word = {23'h0, bp_reg, permit_reg, 7'h00};

  // Read data selection
  wire [7:0] ra = araddr;
  wire rd_hit = (ra == mac_pkg::OFS_CTRL) | (ra == mac_pkg::OFS_CFG) |
                (ra == mac_pkg::OFS_SR)   | (ra == mac_pkg::OFS_TAR) |
                (ra == mac_pkg::OFS_TCR)  | (ra == mac_pkg::OFS_TSR) |
                (ra == mac_pkg::OFS_HASH_LO) | (ra == mac_pkg::OFS_HASH_HI);
  wire [31:0] rd_mux =
      (ra == mac_pkg::OFS_CTRL)    ? ctrl_word :
      (ra == mac_pkg::OFS_CFG)     ? cfg_reg :
      (ra == mac_pkg::OFS_SR)      ? sr_word :
      (ra == mac_pkg::OFS_TAR)     ? tar_view :
      (ra == mac_pkg::OFS_TCR)     ? tcr_view :
      (ra == mac_pkg::OFS_TSR)     ? tsr_word :
      (ra == mac_pkg::OFS_HASH_LO) ? hash_lo_reg :
      (ra == mac_pkg::OFS_HASH_HI) ? hash_hi_reg : 32'h0000_0000;

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= mac_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? mac_pkg::RESP_OKAY : mac_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= mac_pkg::RESP_OKAY;
    end else if (do_read) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_hit ? mac_pkg::RESP_OKAY : mac_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Control, configuration and hash registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bp_reg      <= 1'b0;
      permit_reg  <= 1'b0;
      bump_reg    <= 1'b0;
      cfg_reg     <= mac_pkg::CFG_RESET;
      hash_lo_reg <= 32'h0000_0000;
      hash_hi_reg <= 32'h0000_0000;
      tar_reg     <= 32'h0000_0000;
    end else begin
      bump_reg <= wr_ctrl & wmerged[mac_pkg::CTRL_BUMP];
      if (wr_ctrl && w_strb_reg[0])
        permit_reg <= w_data_reg[mac_pkg::CTRL_PERMIT];
      if (wr_ctrl && w_strb_reg[1])
        bp_reg <= w_data_reg[mac_pkg::CTRL_BP];
      if (wr_cfg)
        cfg_reg <= merge(cfg_reg, w_data_reg, w_strb_reg) &
                   mac_pkg::CFG_WMASK;
      if (wr_hlo)
        hash_lo_reg <= merge(hash_lo_reg, w_data_reg, w_strb_reg);
      if (wr_hhi)
        hash_hi_reg <= merge(hash_hi_reg, w_data_reg, w_strb_reg);
      if (wr_tar)
        tar_reg <= merge(tar_reg, w_data_reg, w_strb_reg);
    end
  end

  // Mode outputs straight from the control and configuration registers
  assign stats_bump_all     = bump_reg;
  assign stats_write_permit = permit_reg;
  assign rate_indicator     = cfg_reg[mac_pkg::CFG_RATE];
  assign full_duplex_select = cfg_reg[mac_pkg::CFG_FD];
  assign backoff_test_mode  = cfg_reg[mac_pkg::CFG_RTY];
  assign rmii_select        = cfg_reg[mac_pkg::CFG_RMII];
  assign rx_max_len = cfg_reg[mac_pkg::CFG_BIG] ? mac_pkg::RX_MAX_LONG
                                                : mac_pkg::RX_MAX_STD;

  // Jam on received frames in half duplex
  wire jam_start = bp_reg & ~cfg_reg[mac_pkg::CFG_FD] & rx_frame_start &
                   (jam_cnt_reg == 7'd0);
  assign back_pressure_force = (jam_cnt_reg != 7'd0);
  always_ff @(posedge aclk) begin
    if (!aresetn)
      jam_cnt_reg <= 7'd0;
    else if (jam_start)
      jam_cnt_reg <= mac_pkg::JAM_BITS;
    else if (bit_tick && jam_cnt_reg != 7'd0)
      jam_cnt_reg <= jam_cnt_reg - 7'd1;
  end

  // Destination address filter
  wire [31:0] crc_full = dest_crc(dest_addr);
  wire [5:0]  hash_idx = crc_full[5:0];
  wire [63:0] hash_vec = {hash_hi_reg, hash_lo_reg};
  wire        hash_hit = hash_vec[hash_idx];
  wire        is_bcast = &dest_addr;
  wire        is_mcast = dest_addr[0] & ~is_bcast;
  wire        hash_ok  = hash_hit &
                  (is_mcast ? cfg_reg[mac_pkg::CFG_MTI]
                            : (~is_bcast & cfg_reg[mac_pkg::CFG_UNI]));
  wire        bcast_ok = is_bcast & ~cfg_reg[mac_pkg::CFG_NBC];
  wire        accept_now = cfg_reg[mac_pkg::CFG_CAF] | sa_match |
                           bcast_ok | hash_ok;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      accept_reg <= 1'b0;
    else
      accept_reg <= dest_valid & accept_now;
  end
  assign frame_accept = accept_reg;

  // Management clock divider, half period 4 << code
  wire [5:0] mdc_half = mac_pkg::MDC_HALF_BASE <<
                        cfg_reg[mac_pkg::CFG_CLK +: 2];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mdc_cnt_reg <= 6'd0;
      mdc_reg     <= 1'b0;
    end else if (mdc_cnt_reg >= mdc_half - 6'd1) begin
      mdc_cnt_reg <= 6'd0;
      mdc_reg     <= ~mdc_reg;
    end else begin
      mdc_cnt_reg <= mdc_cnt_reg + 6'd1;
    end
  end
  assign mdc_out = mdc_reg;

  // Transmit queue: one frame in flight, one waiting
  wire [31:0] tcr_merged = merge({16'h0, 1'b0, 4'h0, 11'h000},
                                 w_data_reg, w_strb_reg);
  wire mac_pkg::tx_desc_s new_desc = '{addr:  tar_reg,
                                       len:   wr_len,
                                       nocrc: tcr_merged[mac_pkg::TCR_SKIP_FCS_APPEND]};
  always_comb begin
    q_next     = q_reg;
    cur_next   = cur_reg;
    pend_next  = pend_reg;
    start_next = 1'b0;
    case (q_reg)
      mac_pkg::TQ_EMPTY: begin
        if (len_go) begin
          cur_next = new_desc;
          q_next   = mac_pkg::TQ_ONE;
        end
      end
      mac_pkg::TQ_ONE: begin
        if (tx_done && len_go) begin
          cur_next = new_desc;
        end else if (tx_done) begin
          q_next = mac_pkg::TQ_EMPTY;
        end else if (len_go) begin
          pend_next = new_desc;
          q_next    = mac_pkg::TQ_TWO;
        end
      end
      mac_pkg::TQ_TWO: begin
        if (tx_done) begin
          cur_next = pend_reg;
          q_next   = mac_pkg::TQ_ONE;
        end
      end
      default: q_next = mac_pkg::TQ_EMPTY;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg    <= mac_pkg::TQ_EMPTY;
      cur_reg  <= '0;
      pend_reg <= '0;
    end else begin
      q_reg    <= q_next;
      cur_reg  <= cur_next;
      pend_reg <= pend_next;
    end
  end

  // Frame presented to the transmit path
  assign tx_desc = cur_reg;
  assign tx_go   = ~tx_idle & (tx_fifo_words >= mac_pkg::TX_MIN_WORDS);
  assign tx_oversize = ~tx_idle &
      (cur_reg.len > (cur_reg.nocrc ? mac_pkg::TX_MAX_RAW
                                    : mac_pkg::TX_MAX_FCS));

  // Sticky transmit flags: a set wins over a same-cycle clear
  wire [6:0] flag_clr = wr_tsr ? wmerged[6:0] : 7'h00;
  wire [6:0] flag_set;
  assign flag_set[mac_pkg::TSR_OVR]  = (wr_tar | wr_tcr) & ~slot_free;
  assign flag_set[mac_pkg::TSR_COL]  = tx_col & ~cfg_reg[mac_pkg::CFG_FD];
  assign flag_set[mac_pkg::TSR_RLE]  = tx_retry_limit;
  assign flag_set[4:3]               = 2'b00;
  assign flag_set[mac_pkg::TSR_COMP] = tx_done & ~tx_idle;
  assign flag_set[mac_pkg::TSR_UND]  = tx_underrun;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      tsr_flags_reg <= 7'h00;
    else
      tsr_flags_reg <= (tsr_flags_reg & ~flag_clr) | flag_set;
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_len_queued;
    len_go && q_reg == mac_pkg::TQ_ONE && !tx_done;
  endsequence
  sequence s_slot_taken;
    ##1 (q_reg == mac_pkg::TQ_TWO) && !tsr_word[mac_pkg::TSR_BNQ];
  endsequence

  write_resp_a: assert property (do_write |=> bvalid ##0 bvalid[*1])
    else $error("write not answered");
  queue_full_a: assert property (s_len_queued |-> s_slot_taken)
    else $error("slot flag stayed set with two frames");
  overrun_flag_a: assert property ((wr_tar || wr_tcr) && !slot_free |=>
                                   tsr_flags_reg[mac_pkg::TSR_OVR])
    else $error("overrun not flagged");
  idle_clear_a: assert property (len_go |=> !tx_idle)
    else $error("idle stayed set after length write");
  complete_flag_a: assert property (tx_done && !tx_idle |=>
                                    tsr_flags_reg[mac_pkg::TSR_COMP])
    else $error("complete flag missed");
  jam_length_a: assert property ($rose(back_pressure_force) |->
                                 jam_cnt_reg == 7'd64)
    else $error("jam does not span 64 bits");
  accept_all_a: assert property (dest_valid &&
                                 cfg_reg[mac_pkg::CFG_CAF] |=> frame_accept)
    else $error("copy-all frame dropped");
  bcast_reject_a: assert property (dest_valid && is_bcast && !sa_match &&
                    cfg_reg[mac_pkg::CFG_NBC] && !cfg_reg[mac_pkg::CFG_CAF]
                    |=> !frame_accept)
    else $error("broadcast accepted while rejected");
  fifo_wait_a: assert property (tx_go |-> tx_fifo_words >= 3'd2)
    else $error("transmit released before two words");
  mdc_rate_a: assert property ($rose(mdc_out) &&
                    cfg_reg[mac_pkg::CFG_CLK +: 2] == 2'b00 &&
                    $stable(cfg_reg) |-> ##1 mdc_out[*3])
    else $error("management clock high phase too short");
  long_frame_a: assert property (cfg_reg[mac_pkg::CFG_BIG] |->
                                 rx_max_len == 11'd1522)
    else $error("long frame limit wrong");
endmodule

// ===== tx_far_model.sv
// Far side stand-in: transmit FIFO fill, frame end pulses, bit ticks.
// Assumes one aclk domain; stall keeps the FIFO empty.
`timescale 1ns/1ps
module tx_far_model #(parameter int LAT = 30) (
  input  wire logic       aclk,    // Clock
  input  wire logic       aresetn, // Sync reset, low
  input  wire logic       stall,   // Hold FIFO empty
  input  wire logic       tx_go,   // Frame may go out
  output logic      [2:0] words,   // FIFO fill in words
  output logic            done,    // Frame end pulse
  output logic            tick     // Bit time pulse
);
  int cnt;
  // Load two words, then end the frame LAT cycles into tx_go
  always_ff @(posedge aclk) begin
    tick <= aresetn;
    done <= aresetn && !stall && tx_go && cnt == LAT;
    if (!aresetn || stall || done) words <= 3'h0;
    else if (words < 3'h2) words <= words + 3'h1;
    cnt <= (tx_go && !done && cnt < LAT) ? cnt + 1 : 0;
  end
endmodule

// ===== tb.sv
// Self-checking bench: register traffic, filter, jam and queue runs.
// Assumes mac_pkg, the queue block and tx_far_model are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, stall, sa_match;
  logic        stats_bump_all, stats_write_permit, rx_frame_start, bit_tick;
  logic        back_pressure_force, rate_indicator, full_duplex_select;
  logic        backoff_test_mode, rmii_select, frame_accept, mdc_out;
  logic        mdio_in, mgmt_busy, tx_go, tx_oversize, tx_done, dest_valid;
  logic        tx_col;
  logic [1:0]  bresp, rresp, lr;
  logic [2:0]  tx_fifo_words;
  logic [3:0]  wstrb;
  logic [7:0]  awaddr, araddr;
  logic [10:0] rx_max_len;
  logic [31:0] wdata, rdata;
  logic [47:0] dest_addr;
  mac_pkg::tx_desc_s tx_desc;
  int          errors, compares, bumps, accs, c;
  time         t0;
  mac_cfg_txq DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .stats_bump_all,
    .stats_write_permit, .rx_frame_start, .bit_tick, .back_pressure_force,
    .rate_indicator, .full_duplex_select, .backoff_test_mode, .rmii_select,
    .rx_max_len, .dest_addr, .dest_valid, .sa_match, .frame_accept,
    .mdc_out, .mdio_in, .mgmt_busy, .tx_desc, .tx_go, .tx_oversize,
    .tx_fifo_words, .tx_done, .tx_col, .tx_retry_limit(tx_col),
    .tx_underrun(1'b0));
  tx_far_model #(.LAT(30)) far (.aclk, .aresetn, .stall, .tx_go,
    .words(tx_fifo_words), .done(tx_done), .tick(bit_tick));
  // Clock, 5 ns period
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Count one-cycle pulses away from the active edge
  always @(negedge aclk) begin
    bumps += (stats_bump_all === 1'b1);
    accs += (frame_accept === 1'b1);
  end
  // Write: offer address and data, drop each once taken, await response
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s = 4'hF);
    logic ta, tw, tr;
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge aclk); ta = awready; tw = wready; tr = bvalid; lr = bresp;
      @(posedge aclk); if (ta) awvalid <= 1'b0; if (tw) wvalid <= 1'b0;
    end while (!tr);
    bready <= 1'b0;
  endtask
  // Read one word and compare it
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic ta, tr;
    logic [31:0] q;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge aclk); ta = arready; tr = rvalid; q = rdata; lr = rresp;
      @(posedge aclk); if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
    `CHK(q, e)
  endtask
  // Present one destination, count whether it is kept
  task automatic flt(input logic [31:0] cfg, input logic sa,
                     input logic [47:0] da, input int e);
    c = accs;
    wr(8'h04, cfg);
    sa_match <= sa; dest_addr <= da; dest_valid <= 1'b1;
    @(posedge aclk) dest_valid <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK(accs - c, e)
  endtask
  // Counts, verdict, stop
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    repeat (8000) @(posedge aclk);
    errors++;
    end_sim();
  end
  // Reset, then register, jam, clock, filter and queue sequences
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {tx_col, rx_frame_start, dest_valid, sa_match} = 4'h0;
    {stall, mdio_in, mgmt_busy} = 3'h7;
    {awaddr, araddr, wdata, wstrb, dest_addr} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h04, 32'h800);
    rc(8'h08, 32'h6);
    mdio_in <= 1'b0;
    rc(8'h08, 32'h4);
    rc(8'h14, 32'h18);
    rc(8'h40, 32'h0);
    `CHK(lr, mac_pkg::RESP_SLVERR)
    wr(8'h04, 32'h3903);
    `CHK({rate_indicator, full_duplex_select, backoff_test_mode, rmii_select}, 4'hF)
    `CHK(rx_max_len, 11'd1522)
    wr(8'h04, 32'hFFFF_FFFF, 4'h1);
    rc(8'h04, 32'h39F3);
    wr(8'h04, 32'h800);
    `CHK({rate_indicator, rx_max_len}, {1'b0, 11'd1518})
    wr(8'h00, 32'hC0);
    repeat (3) @(posedge aclk);
    `CHK({bumps, stats_write_permit}, {32'd1, 1'b1})
    rc(8'h00, 32'h80);
    wr(8'h00, 32'h100);
    rx_frame_start <= 1'b1;
    @(posedge aclk) rx_frame_start <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK(back_pressure_force, 1'b1)
    repeat (70) @(posedge aclk);
    `CHK(back_pressure_force, 1'b0)
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, 32'(k) << 10);
      repeat (2) @(posedge mdc_out);
      t0 = $time;
      @(posedge mdc_out);
      `CHK(($time - t0) / 5, 64'(8 << k))
    end
    flt(32'h10, 1'b0, 48'h2, 1);
    flt(32'h0, 1'b1, 48'h2, 1);
    flt(32'h20, 1'b0, '1, 0);
    flt(32'h0, 1'b0, '1, 1);
    flt(32'h80, 1'b0, 48'h2, 0);
    wr(8'h90, 32'hFFFF_FFFF);
    wr(8'h94, 32'hFFFF_FFFF);
    flt(32'h80, 1'b0, 48'h2, 1);
    flt(32'h40, 1'b0, 48'h2, 0);
    flt(32'h40, 1'b0, 48'h1, 1);
    wr(8'h0C, 32'h1000_0002);
    wr(8'h10, 32'd100);
    `CHK({tx_desc, tx_go}, {32'h1000_0002, 11'd100, 2'b00})
    rc(8'h14, 32'h10);
    wr(8'h0C, 32'h2000_0000);
    wr(8'h10, 32'h8640);
    rc(8'h14, 32'h0);
    rc(8'h10, 32'd100);
    rc(8'h0C, 32'h1000_0002);
    wr(8'h10, 32'd80);
    rc(8'h14, 32'h1);
    wr(8'h14, 32'h1);
    rc(8'h14, 32'h0);
    stall <= 1'b0;
    repeat (45) @(posedge aclk);
    `CHK({tx_desc, tx_oversize}, {32'h2000_0000, 11'd1600, 2'b11})
    rc(8'h14, 32'h30);
    repeat (50) @(posedge aclk);
    rc(8'h14, 32'h38);
    wr(8'h14, 32'h20);
    rc(8'h14, 32'h18);
    // Collision and retry limit in half duplex, then in full duplex
    tx_col <= 1'b1;
    @(posedge aclk) tx_col <= 1'b0;
    rc(8'h14, 32'h1E);
    wr(8'h14, 32'h6);
    wr(8'h04, 32'h2);
    tx_col <= 1'b1;
    @(posedge aclk) tx_col <= 1'b0;
    rc(8'h14, 32'h1C);
    wr(8'h14, 32'h4);
    rc(8'h14, 32'h18);
    end_sim();
  end
endmodule
